// [hdl/bdd_params.svh]
`ifndef BDD_PARAMS_SVH
`define BDD_PARAMS_SVH
`define BDD_A_SPI_CFG    16'h0000
`define BDD_A_PWR_MODE   16'h0008
`define BDD_A_PIDX       16'h010C
`define BDD_A_FILT_CTL   16'h0113
`define BDD_A_TW_FREQ    16'h0117
`define BDD_A_TW_AMP     16'h0118
`define BDD_A_TW_OFS     16'h0119
`define BDD_A_TW_CHEN    16'h011A
`define BDD_A_TW_GEN     16'h011B
`define BDD_COEF_PAGE    4'h1
`define BDD_CFG_LSB_BIT  6
`define BDD_PIDX_TRG_BIT 5
`define BDD_FC_GAIN4_BIT 4
`define BDD_FC_CHECK_BIT 6
`define BDD_FC_ADVP_BIT  7
`define BDD_TG_EN_BIT    0
`define BDD_TG_ID_BIT    1
`define BDD_NIB_LSB      4'h0
`define BDD_NIB_MSB      4'hF
`define BDD_LAST_BYTE    4'hD
`define BDD_PAD_BYTES    4'h2
`define BDD_RUN_MODE     3'h0
`define BDD_FILL_OUTS    6'h20
`define BDD_TAPS         16
`define BDD_HALF_TAPS    8
`define BDD_COEF_W       14
`define BDD_TW_FS        32'h0000_1FFF
`define BDD_TW_REF       4'hD
`define BDD_MIX_SHIFT    11
`define BDD_G4_SHIFT     4'h2
`endif

// [hdl/bdd_pkg.sv]
package bdd_pkg;
   typedef struct packed {
      logic [15:0] freq;
      logic [7:0]  ptr;
      logic [4:0]  dec;
      logic [2:0]  gain;
      logic [14:0] power_stop;
   } bdd_profile_s;
   typedef struct packed {
      logic [15:0] i;
      logic [15:0] q;
   } bdd_iq_s;
   typedef enum logic {BDD_IDLE, BDD_RUN} bdd_state_e;
   typedef logic [111:0] bdd_block_t;
endpackage : bdd_pkg

// [hdl/bdd_top.sv]
`timescale 1ns/1ps
`include "bdd_params.svh"
module bdd_top #(
   parameter logic [2:0] CHAN  = 3'h0,
   parameter int         ACC_W = 40,
   parameter int         NBLK  = 256
) (
   input  wire logic                  I_CLOCK,
   input  wire logic                  I_SYS_RST,
   input  wire logic                  I_TRANSMIT_TRIGGER,
   input  wire logic                  I_RF_DEC_EN,
   input  wire logic                  I_SAMPLE_VALID,
   input  wire logic [15:0]           I_SAMPLE,
   input  wire logic [4:0]            I_CHIP_ADDR,
   input  wire bdd_pkg::bdd_profile_s I_PROFILE,
   input  wire logic                  I_REG_WR,
   input  wire logic                  I_REG_RD,
   input  wire logic [15:0]           I_REG_ADDR,
   input  wire logic [7:0]            I_REG_WDATA,
   output logic [7:0]                 O_REG_RDATA,
   output logic [4:0]                 O_PROFILE_IDX,
   output logic                       O_RUNNING,
   output bdd_pkg::bdd_iq_s           O_IQ,
   output logic                       O_IQ_VALID,
   output logic                       O_POPULATED
);
   import bdd_pkg::*;

   // register file
   logic [7:0] spi_cfg_reg, spi_cfg_next, pwr_mode_reg, pwr_mode_next;
   logic [7:0] filt_ctl_reg, filt_ctl_next, tw_freq_reg, tw_freq_next;
   logic [7:0] tw_amp_reg, tw_amp_next, tw_ofs_reg, tw_ofs_next;
   logic [7:0] tw_chen_reg, tw_chen_next, tw_gen_reg, tw_gen_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [4:0] pidx_reg, pidx_next;
   // control
   logic         trig_s1_reg, trig_s2_reg, trig_d_reg, half_reg, half_next;
   bdd_state_e   state_reg, state_next;
   logic [14:0]  pcnt_reg, pcnt_next;
   logic         pcnt_on_reg, pcnt_on_next, prof_ld_reg, prof_ld_next;
   bdd_profile_s prof_reg, prof_next;
   // coefficient memory
   bdd_block_t   mem_reg [NBLK];
   bdd_block_t   mem_next [NBLK];
   bdd_block_t   cbuf_reg, cbuf_next;
   logic [7:0]   cblk_reg, cblk_next;
   logic [3:0]   ccnt_reg, ccnt_next;
   // datapath
   logic [15:0]             nco_reg, nco_next;
   logic [4:0]              ph_reg, ph_next;
   logic signed [ACC_W-1:0] acc_i_reg [`BDD_TAPS];
   logic signed [ACC_W-1:0] acc_i_next [`BDD_TAPS];
   logic signed [ACC_W-1:0] acc_q_reg [`BDD_TAPS];
   logic signed [ACC_W-1:0] acc_q_next [`BDD_TAPS];
   bdd_iq_s                 iq_reg, iq_next;
   logic                    vld_reg, vld_next;
   logic [5:0]              outs_reg, outs_next, twph_reg, twph_next;
   logic [6:0]              ramp_reg, ramp_next;

   logic trig_rise, trig_fall, eff_tick, run_mode, lsb_first;
   logic coef_sel, coef_wr, wr_pidx, soft_trig, restart;

   // quarter-wave table, 64 points per turn; shared by oscillator and test source
   function automatic logic signed [11:0] bdd_sin(input logic [5:0] p);
      logic [4:0]  k;
      logic [11:0] m;
      k = p[4] ? 5'(5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
      case (k)
         5'h00: m = 12'h000;
         5'h01: m = 12'h0C9;
         5'h02: m = 12'h191;
         5'h03: m = 12'h253;
         5'h04: m = 12'h310;
         5'h05: m = 12'h3C5;
         5'h06: m = 12'h471;
         5'h07: m = 12'h513;
         5'h08: m = 12'h5A8;
         5'h09: m = 12'h62F;
         5'h0A: m = 12'h6A6;
         5'h0B: m = 12'h70D;
         5'h0C: m = 12'h763;
         5'h0D: m = 12'h7A7;
         5'h0E: m = 12'h7D8;
         5'h0F: m = 12'h7F5;
         default: m = 12'h7FF;
      endcase
      bdd_sin = p[5] ? 12'(-m) : m;
   endfunction : bdd_sin

   assign trig_rise = trig_s2_reg & ~trig_d_reg;
   assign trig_fall = ~trig_s2_reg & trig_d_reg;
   assign eff_tick  = I_SAMPLE_VALID & (~I_RF_DEC_EN | half_reg);
   assign run_mode  = pwr_mode_reg[2:0] == `BDD_RUN_MODE;
   assign lsb_first = spi_cfg_reg[`BDD_CFG_LSB_BIT];
   assign coef_sel  = I_REG_ADDR[15:12] == `BDD_COEF_PAGE;
   assign coef_wr   = I_REG_WR & coef_sel;
   assign wr_pidx   = I_REG_WR & (I_REG_ADDR == `BDD_A_PIDX);
   // a software trigger is the index write with the trigger bit set
   assign soft_trig = wr_pidx & I_REG_WDATA[`BDD_PIDX_TRG_BIT];
   assign restart   = trig_rise | soft_trig;

   always_comb begin : reg_comb
      logic [3:0] ridx;
      ridx          = lsb_first ? I_REG_ADDR[3:0] : 4'(I_REG_ADDR[3:0] - `BDD_PAD_BYTES);
      spi_cfg_next  = spi_cfg_reg;
      pwr_mode_next = pwr_mode_reg;
      pidx_next     = pidx_reg;
      filt_ctl_next = filt_ctl_reg;
      tw_freq_next  = tw_freq_reg;
      tw_amp_next   = tw_amp_reg;
      tw_ofs_next   = tw_ofs_reg;
      tw_chen_next  = tw_chen_reg;
      tw_gen_next   = tw_gen_reg;
      rdata_next    = rdata_reg;
      if (I_REG_WR) begin
         case (I_REG_ADDR)
            `BDD_A_SPI_CFG:  spi_cfg_next  = I_REG_WDATA;
            `BDD_A_PWR_MODE: pwr_mode_next = I_REG_WDATA;
            `BDD_A_PIDX:     pidx_next     = I_REG_WDATA[4:0];
            `BDD_A_FILT_CTL: filt_ctl_next = I_REG_WDATA;
            `BDD_A_TW_FREQ:  tw_freq_next  = I_REG_WDATA;
            `BDD_A_TW_AMP:   tw_amp_next   = I_REG_WDATA;
            `BDD_A_TW_OFS:   tw_ofs_next   = I_REG_WDATA;
            `BDD_A_TW_CHEN:  tw_chen_next  = I_REG_WDATA;
            `BDD_A_TW_GEN:   tw_gen_next   = I_REG_WDATA;
            default: ;
         endcase
      end
      if (I_REG_RD) begin
         rdata_next = 8'h00;
         if (coef_sel) begin
            // padding bytes read as zero
            if (ridx <= `BDD_LAST_BYTE)
               rdata_next = mem_reg[I_REG_ADDR[11:4]][{ridx, 3'h0} +: 8];
         end else begin
            case (I_REG_ADDR)
               `BDD_A_SPI_CFG:  rdata_next = spi_cfg_reg;
               `BDD_A_PWR_MODE: rdata_next = pwr_mode_reg;
               `BDD_A_PIDX:     rdata_next = {3'h0, pidx_reg};
               `BDD_A_FILT_CTL: rdata_next = filt_ctl_reg;
               `BDD_A_TW_FREQ:  rdata_next = tw_freq_reg;
               `BDD_A_TW_AMP:   rdata_next = tw_amp_reg;
               `BDD_A_TW_OFS:   rdata_next = tw_ofs_reg;
               `BDD_A_TW_CHEN:  rdata_next = tw_chen_reg;
               `BDD_A_TW_GEN:   rdata_next = tw_gen_reg;
               default:         rdata_next = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         spi_cfg_reg  <= 8'h00;
         pwr_mode_reg <= 8'h00;
         pidx_reg     <= 5'h00;
         filt_ctl_reg <= 8'h00;
         tw_freq_reg  <= 8'h00;
         tw_amp_reg   <= 8'h00;
         tw_ofs_reg   <= 8'h00;
         tw_chen_reg  <= 8'h00;
         tw_gen_reg   <= 8'h00;
         rdata_reg    <= 8'h00;
      end else begin
         spi_cfg_reg  <= spi_cfg_next;
         pwr_mode_reg <= pwr_mode_next;
         pidx_reg     <= pidx_next;
         filt_ctl_reg <= filt_ctl_next;
         tw_freq_reg  <= tw_freq_next;
         tw_amp_reg   <= tw_amp_next;
         tw_ofs_reg   <= tw_ofs_next;
         tw_chen_reg  <= tw_chen_next;
         tw_gen_reg   <= tw_gen_next;
         rdata_reg    <= rdata_next;
      end
   end

   always_comb begin : ctl_comb
      half_next    = (I_SAMPLE_VALID & I_RF_DEC_EN) ? ~half_reg : half_reg;
      state_next   = state_reg;
      pcnt_next    = pcnt_reg;
      pcnt_on_next = pcnt_on_reg;
      prof_ld_next = wr_pidx;
      // profile memory follows the new index one cycle after the write
      prof_next    = prof_ld_reg ? I_PROFILE : prof_reg;
      if (trig_rise) begin
         pcnt_next    = 15'h0000;
         pcnt_on_next = 1'b1;
      end else if (pcnt_on_reg) begin
         pcnt_next = 15'(pcnt_reg + 15'h0001);
      end
      if (!run_mode) begin
         state_next = BDD_IDLE;
      end else if (soft_trig) begin
         state_next = BDD_RUN;
      end else if (trig_rise | wr_pidx) begin
         state_next = BDD_IDLE;
      end else if (pcnt_on_reg && pcnt_reg == prof_reg.power_stop &&
                   filt_ctl_reg[`BDD_FC_ADVP_BIT]) begin
         state_next   = BDD_IDLE;
         pcnt_on_next = 1'b0;
      end else if (trig_fall) begin
         state_next = BDD_RUN;
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         trig_s1_reg <= 1'b0;
         trig_s2_reg <= 1'b0;
         trig_d_reg  <= 1'b0;
         half_reg    <= 1'b0;
         state_reg   <= BDD_IDLE;
         pcnt_reg    <= 15'h0000;
         pcnt_on_reg <= 1'b0;
         prof_ld_reg <= 1'b0;
         prof_reg    <= '0;
      end else begin
         trig_s1_reg <= I_TRANSMIT_TRIGGER;
         trig_s2_reg <= trig_s1_reg;
         trig_d_reg  <= trig_s2_reg;
         half_reg    <= half_next;
         state_reg   <= state_next;
         pcnt_reg    <= pcnt_next;
         pcnt_on_reg <= pcnt_on_next;
         prof_ld_reg <= prof_ld_next;
         prof_reg    <= prof_next;
      end
   end

   always_comb begin : coef_comb
      logic [7:0] blk;
      logic [3:0] bpos;
      blk       = cblk_reg;
      bpos      = 4'h0;
      mem_next  = mem_reg;
      cbuf_next = cbuf_reg;
      cblk_next = cblk_reg;
      ccnt_next = ccnt_reg;
      if (coef_wr) begin
         // only a boundary address opens a block; later bytes follow the counter
         if (ccnt_reg == 4'h0 &&
             I_REG_ADDR[3:0] == (lsb_first ? `BDD_NIB_LSB : `BDD_NIB_MSB))
            blk = I_REG_ADDR[11:4];
         bpos = lsb_first ? ccnt_reg : 4'(`BDD_LAST_BYTE - ccnt_reg);
         cbuf_next[{bpos, 3'h0} +: 8] = I_REG_WDATA;
         if (ccnt_reg == `BDD_LAST_BYTE) begin
            mem_next[blk] = cbuf_next;
            cblk_next     = lsb_first ? 8'(blk + 8'h01) : 8'(blk - 8'h01);
            ccnt_next     = 4'h0;
         end else begin
            cblk_next = blk;
            ccnt_next = 4'(ccnt_reg + 4'h1);
         end
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         for (int b = 0; b < NBLK; b++) mem_reg[b] <= '0;
         cbuf_reg <= '0;
         cblk_reg <= 8'h00;
         ccnt_reg <= 4'h0;
      end else begin
         mem_reg  <= mem_next;
         cbuf_reg <= cbuf_next;
         cblk_reg <= cblk_next;
         ccnt_reg <= ccnt_next;
      end
   end

   always_comb begin : dp_comb
      logic signed [ACC_W-1:0] ti [`BDD_TAPS];
      logic signed [ACC_W-1:0] tq [`BDD_TAPS];
      logic signed [ACC_W-1:0] sh_i, sh_q;
      logic signed [27:0]      mp;
      logic signed [15:0]      src, mix_i, mix_q, amp;
      logic [31:0]             ofs;
      logic [3:0]              osh, gsh;
      logic [4:0]              r, jj;
      logic [7:0]              blk;
      logic signed [13:0]      coef;
      int                      ci;
      for (int s = 0; s < `BDD_TAPS; s++) begin
         ti[s] = '0;
         tq[s] = '0;
      end
      nco_next  = nco_reg;
      ph_next   = ph_reg;
      acc_i_next = acc_i_reg;
      acc_q_next = acc_q_reg;
      iq_next   = iq_reg;
      vld_next  = 1'b0;
      outs_next = outs_reg;
      twph_next = twph_reg;
      ramp_next = ramp_reg;
      r = 5'h00;
      jj = 5'h00;
      blk = 8'h00;
      coef = '0;
      ci = 0;
      if (I_SAMPLE_VALID) begin
         twph_next = 6'(twph_reg + tw_freq_reg[5:0]);
         ramp_next = 7'(ramp_reg + 7'h01);
      end
      // C + A sin: amplitude FS/2^x, offset FS*a*2^-(13-b)
      amp = 16'(`BDD_TW_FS >> tw_amp_reg[3:0]);
      osh = (tw_ofs_reg[3:0] > `BDD_TW_REF) ? 4'h0 : 4'(`BDD_TW_REF - tw_ofs_reg[3:0]);
      ofs = (`BDD_TW_FS * {28'h0, tw_ofs_reg[7:4]}) >> osh;
      mp  = 28'(amp * bdd_sin(twph_reg));
      src = (tw_gen_reg[`BDD_TG_EN_BIT] & tw_chen_reg[CHAN]) ?
            16'(ofs[15:0] + 16'(mp >>> `BDD_MIX_SHIFT)) : $signed(I_SAMPLE);
      mp    = 28'(src * bdd_sin(6'(nco_reg[15:10] + 6'h10)));
      mix_i = 16'(mp >>> `BDD_MIX_SHIFT);
      mp    = 28'(src * 12'(-bdd_sin(nco_reg[15:10])));
      mix_q = 16'(mp >>> `BDD_MIX_SHIFT);
      if (tw_gen_reg[`BDD_TG_EN_BIT] & tw_chen_reg[CHAN] & tw_gen_reg[`BDD_TG_ID_BIT]) begin
         mix_i = {I_CHIP_ADDR, CHAN, 1'b0, ramp_reg};
         mix_q = {I_CHIP_ADDR, CHAN, 1'b1, ramp_reg};
      end
      for (int s = 0; s < `BDD_TAPS; s++) begin
         // first half walks coefficients forward, second half mirrors them
         ci   = (s < `BDD_HALF_TAPS) ? s : `BDD_TAPS - 1 - s;
         r    = (s < `BDD_HALF_TAPS) ? ph_reg : 5'(prof_reg.dec - ph_reg);
         jj   = ci[0] ? r : 5'(prof_reg.dec - r);
         blk  = 8'(prof_reg.ptr + {3'h0, jj});
         coef = mem_reg[blk][`BDD_COEF_W*ci +: `BDD_COEF_W];
         ti[s] = acc_i_reg[s] + ACC_W'(mix_i * coef);
         tq[s] = acc_q_reg[s] + ACC_W'(mix_q * coef);
      end
      gsh  = 4'({1'b0, prof_reg.gain}) + (filt_ctl_reg[`BDD_FC_GAIN4_BIT] ? `BDD_G4_SHIFT : 4'h0);
      sh_i = ti[`BDD_TAPS-1] <<< gsh;
      sh_q = tq[`BDD_TAPS-1] <<< gsh;
      if (restart) begin
         nco_next  = 16'h0000;
         ph_next   = 5'h00;
         outs_next = 6'h00;
         for (int s = 0; s < `BDD_TAPS; s++) begin
            acc_i_next[s] = '0;
            acc_q_next[s] = '0;
         end
      end else if (state_reg == BDD_RUN && eff_tick) begin
         nco_next = 16'(nco_reg + prof_reg.freq);
         if (ph_reg == prof_reg.dec) begin
            // oldest window completes; everything ages by one step
            vld_next = 1'b1;
            ph_next  = 5'h00;
            iq_next.i = filt_ctl_reg[`BDD_FC_CHECK_BIT] ? ti[`BDD_TAPS-1][15:0]
                                                        : sh_i[ACC_W-1 -: 16];
            iq_next.q = filt_ctl_reg[`BDD_FC_CHECK_BIT] ? tq[`BDD_TAPS-1][15:0]
                                                        : sh_q[ACC_W-1 -: 16];
            if (outs_reg != `BDD_FILL_OUTS) outs_next = 6'(outs_reg + 6'h01);
            acc_i_next[0] = '0;
            acc_q_next[0] = '0;
            for (int s = 1; s < `BDD_TAPS; s++) begin
               acc_i_next[s] = ti[s-1];
               acc_q_next[s] = tq[s-1];
            end
         end else begin
            ph_next    = 5'(ph_reg + 5'h01);
            acc_i_next = ti;
            acc_q_next = tq;
         end
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         nco_reg  <= 16'h0000;
         ph_reg   <= 5'h00;
         for (int s = 0; s < `BDD_TAPS; s++) begin
            acc_i_reg[s] <= '0;
            acc_q_reg[s] <= '0;
         end
         iq_reg   <= '0;
         vld_reg  <= 1'b0;
         outs_reg <= 6'h00;
         twph_reg <= 6'h00;
         ramp_reg <= 7'h00;
      end else begin
         nco_reg   <= nco_next;
         ph_reg    <= ph_next;
         acc_i_reg <= acc_i_next;
         acc_q_reg <= acc_q_next;
         iq_reg    <= iq_next;
         vld_reg   <= vld_next;
         outs_reg  <= outs_next;
         twph_reg  <= twph_next;
         ramp_reg  <= ramp_next;
      end
   end

   assign O_REG_RDATA   = rdata_reg;
   assign O_PROFILE_IDX = pidx_reg;
   assign O_RUNNING     = state_reg == BDD_RUN;
   assign O_IQ          = iq_reg;
   assign O_IQ_VALID    = vld_reg;
   assign O_POPULATED   = outs_reg == `BDD_FILL_OUTS;

   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_SYS_RST);

   sequence s_blk_done;
      coef_wr && ccnt_reg == `BDD_LAST_BYTE;
   endsequence
   sequence s_pidx_load;
      wr_pidx ##1 prof_ld_reg;
   endsequence

   a_trig_clears_nco: assert property (trig_rise |=> nco_reg == 16'h0000 && ph_reg == 5'h00)
      else $error("oscillator or phase not cleared by trigger");
   a_trig_to_idle: assert property (trig_rise && !soft_trig |=> state_reg == BDD_IDLE)
      else $error("trigger rise did not idle the block");
   a_fall_to_run: assert property (trig_fall && run_mode && !wr_pidx &&
                                    !filt_ctl_reg[`BDD_FC_ADVP_BIT]
                                    |=> state_reg == BDD_RUN)
      else $error("trigger fall did not start the block");
   a_soft_trig_run: assert property (soft_trig && run_mode |=> O_RUNNING)
      else $error("software trigger did not start the block");
   a_prof_reload: assert property (s_pidx_load |=> prof_reg == $past(I_PROFILE))
      else $error("profile not reloaded after index write");
   a_blk_step: assert property (s_blk_done |=> ccnt_reg == 4'h0 &&
                   cblk_reg == ($past(lsb_first) ? 8'($past(cblk_reg) + 8'h01)
                                                 : 8'($past(cblk_reg) - 8'h01)))
      else $error("block address did not step after 14 bytes");
   a_out_rate: assert property (vld_reg |-> $past(ph_reg) == prof_reg.dec ||
                                $past(prof_ld_reg))
      else $error("output emitted off the decimation boundary");
   a_half_rate: assert property (eff_tick && I_RF_DEC_EN ##1 I_RF_DEC_EN |-> !eff_tick)
      else $error("two effective ticks in a row with decimator on");
   a_fill_flag: assert property (restart |=> !O_POPULATED)
      else $error("populated flag survived a filter reset");
endmodule : bdd_top

// [tb/bdd_far_model.sv]
`timescale 1ns/1ps
module bdd_far_model (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_go,
   input  wire logic [11:0]      i_count,
   input  wire logic [15:0]      i_data,
   input  wire logic [4:0]       i_idx,
   output logic                  o_valid,
   output logic [15:0]           o_sample,
   output logic                  o_busy,
   output bdd_pkg::bdd_profile_s o_profile
);
   import bdd_pkg::*;
   logic [11:0] left_reg;
   logic [15:0] data_reg;
   // between samples the bus shows the inverse, so a stale word never passes
   assign o_sample  = o_valid ? data_reg : ~data_reg;
   assign o_busy    = (left_reg != 12'h000) || o_valid;
   // profile memory: index k decimates by k+1
   assign o_profile = '{freq: {i_idx, 11'h155}, ptr: {3'h0, i_idx}, dec: i_idx,
                        gain: i_idx[2:0], power_stop: 15'h7FFF};
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         left_reg <= 12'h000;
         o_valid  <= 1'b0;
         data_reg <= 16'h0000;
      end else if (i_go) begin
         left_reg <= i_count;
      end else if (left_reg != 12'h000 && !o_valid) begin
         left_reg <= left_reg - 12'h001;
         o_valid  <= 1'b1;
         data_reg <= i_data;
      end else begin
         o_valid  <= 1'b0;
      end
   end
endmodule : bdd_far_model

// [tb/bdd_top_bench.sv]
`timescale 1ns/1ps
module bdd_top_bench;
   import bdd_pkg::*;
   logic         clk, rst, trig, rfd, wr, rd, go, run, iqv, pop, sv, busy;
   logic [15:0]  addr, smp;
   logic [7:0]   wdat, rdata, got;
   logic [4:0]   pidx;
   logic [11:0]  cnt;
   logic [31:0]  rnd = 32'h49D7;
   logic         imp = 1'b0;
   logic [15:0]  ival = 16'h0000;
   bdd_iq_s      iq;
   bdd_profile_s prof;
   int           bad_count = 0, compares = 0, outs = 0, n;
   logic [7:0]   blk [28];
   logic [4:0]   dl [4] = '{5'h00, 5'h03, 5'h1F, 5'h01};
   bdd_top u_bdd_top (.I_CLOCK(clk), .I_SYS_RST(rst), .I_TRANSMIT_TRIGGER(trig), .I_RF_DEC_EN(rfd),
      .I_SAMPLE_VALID(sv), .I_SAMPLE(smp), .I_CHIP_ADDR(5'h0A), .I_PROFILE(prof),
      .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdat),
      .O_REG_RDATA(rdata), .O_PROFILE_IDX(pidx), .O_RUNNING(run), .O_IQ(iq),
      .O_IQ_VALID(iqv), .O_POPULATED(pop));
   bdd_far_model u_bdd_far_model (.i_clk(clk), .i_rst(rst), .i_go(go), .i_count(cnt),
      .i_data(imp ? ival : rnd[15:0]), .i_idx(pidx), .o_valid(sv), .o_sample(smp),
      .o_busy(busy),
      .o_profile(prof));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (iqv === 1'b1) begin
         if (imp && outs < 17) begin
            chk("impulse i", {16'h0, imp_exp(outs)}, {16'h0, iq.i});
            chk("impulse q", 32'h0, {16'h0, iq.q});
         end
         outs++;
      end
   end
   // block 0 taps 0..7 then mirrored; the mixer's cosine at phase zero is 0x7FF
   function automatic logic [15:0] imp_exp(input int k);
      logic [111:0] v;
      for (int b = 0; b < 14; b++) v[8*b +: 8] = blk[b];
      if (k > 15) return 16'h0000;
      return 16'(32'sh7FF * $signed(v[14*(k < 8 ? k : 15 - k) +: 14]));
   endfunction : imp_exp
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic int fac(input logic [4:0] d, input logic r);
      return (d + 1) * (r ? 2 : 1);
   endfunction : fac
   task automatic tick;
      @(posedge clk);
      #1;
      rnd = lfsr(rnd);
   endtask : tick
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic wreg(input logic [15:0] a, input logic [7:0] d);
      addr = a;
      wdat = d;
      wr   = 1'b1;
      tick;
      wr   = 1'b0;
      tick;
   endtask : wreg
   task automatic rreg(input logic [15:0] a);
      addr = a;
      rd   = 1'b1;
      tick;
      rd   = 1'b0;
      got  = rdata;
      tick;
   endtask : rreg
   task automatic feed(input int k);
      cnt = 12'(k);
      go  = 1'b1;
      tick;
      go  = 1'b0;
      for (int i = 0; i < 9000 && busy; i++) tick;
      repeat (2) tick;
   endtask : feed
   task automatic wrun(input logic v);
      for (int i = 0; i < 8 && run !== v; i++) tick;
      chk("running", v, run);
   endtask : wrun
   task automatic summarize;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      summarize;
   end
   initial begin
      {rst, trig, rfd, wr, rd, go} = 6'h20;
      addr = 16'h0000;
      wdat = 8'h00;
      cnt  = 12'h000;
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      chk("reset outputs", 32'h0, {run, iqv, pop, pidx});
      rreg(16'h0008);
      chk("power mode", 32'h0, got);
      blk[0] = rnd[7:0];
      wreg(16'h0119, blk[0]);
      rreg(16'h0119);
      chk("wave offset", blk[0], got);
      wreg(16'h0050, 8'hFF);
      rreg(16'h0050);
      chk("unmapped", 32'h0, got);
      feed(8);
      chk("idle outputs", 32'h0, outs);
      $display("test registers and idle done");
      foreach (dl[k]) begin
         rfd = (k == 3);
         wreg(16'h010C, {3'h1, dl[k]});
         chk("profile index", dl[k], pidx);
         chk("running", 32'h1, run);
         outs = 0;
         n    = fac(dl[k], rfd);
         feed(31 * n);
         chk("outputs", 32'd31, outs);
         chk("populated", 32'h0, pop);
         feed(n);
         chk("outputs", 32'd32, outs);
         chk("populated", 32'h1, pop);
         feed(n - 1);
         chk("outputs", 32'd32, outs);
      end
      rfd = 1'b0;
      $display("test decimation done");
      wreg(16'h010C, 8'h02);
      chk("running", 32'h0, run);
      outs = 0;
      feed(8);
      chk("idle outputs", 32'h0, outs);
      wreg(16'h010C, 8'h20);
      feed(40);
      trig = 1'b1;
      wrun(1'b0);
      chk("populated", 32'h0, pop);
      trig = 1'b0;
      wrun(1'b1);
      $display("test trigger done");
      wreg(16'h0000, 8'h40);
      // whole blocks from the boundary, byte 0 first in this bit order
      for (int k = 0; k < 28; k++) begin
         blk[k] = rnd[7:0];
         wreg(16'h1000 + 16'(k) + (k > 13 ? 16'h2 : 16'h0), blk[k]);
      end
      for (int k = 0; k < 28; k++) begin
         rreg(16'h1000 + 16'(k) + (k > 13 ? 16'h2 : 16'h0));
         chk("coef byte", blk[k], got);
      end
      rreg(16'h100E);
      chk("pad byte", 32'h0, got);
      wreg(16'h0000, 8'h00);
      // high byte first, opened at the top boundary of block 2
      for (int k = 27; k > 13; k--) begin
         blk[k] = rnd[7:0];
         wreg(16'h1014 + 16'(k), blk[k]);
      end
      for (int k = 14; k < 28; k++) begin
         rreg(16'h1014 + 16'(k));
         chk("msb coef byte", blk[k], got);
      end
      $display("test coefficients done");
      wreg(16'h0113, 8'h40);
      wreg(16'h010C, 8'h20);
      outs = 0;
      imp  = 1'b1;
      ival = 16'h0800;
      feed(1);
      ival = 16'h0000;
      feed(16);
      chk("impulse outputs", 32'd17, outs);
      $display("test impulse done");
      summarize;
   end
endmodule : bdd_top_bench
